// *** src/gdr_pkg.sv ***
package gdr_pkg;
  localparam logic [3:0]  ADDR_STAT1     = 4'h0;
  localparam logic [3:0]  ADDR_STAT2     = 4'h1;
  localparam logic [3:0]  ADDR_CTRL      = 4'h2;
  localparam logic [3:0]  ADDR_LOCK      = 4'h3;
  localparam int          REG_W          = 11;
  localparam int          SNAP_W         = 44;
  localparam logic [7:0]  FRAME_BITS     = 8'h10;
  localparam logic [4:0]  TX_DATA_START  = 5'h05;
  localparam logic [10:0] CTRL_RST       = 11'h000;
  localparam logic [10:0] CTRL_OPEN_MASK = 11'h3fe;
  localparam logic [10:0] CTRL_LOCK_MASK = 11'h006;
  localparam logic [2:0]  LOCK_RST       = 3'h3;
  localparam logic [2:0]  LOCK_ON        = 3'h6;
  localparam logic [2:0]  LOCK_OFF       = 3'h3;
  localparam logic [22:0] SYNC_RST       = 23'h400000;
  localparam int          C_DIS_PUMP     = 9;
  localparam int          C_DIS_GATE     = 8;
  localparam int          C_WARN_REP     = 7;
  localparam int          C_FREEWHEEL    = 4;
  localparam int          C_DIR          = 3;
  localparam int          C_COAST        = 2;
  localparam int          C_BRAKE        = 1;
  localparam int          C_CLEAR        = 0;

  typedef enum logic [1:0] {
    PWM_SIX    = 2'b00,
    PWM_THREE  = 2'b01,
    PWM_SINGLE = 2'b10,
    PWM_INDEP  = 2'b11
  } gdr_pwm_mode_t;

  function automatic logic [7:0] gdr_bin2gray(input logic [7:0] b);
    return b ^ (b >> 1);
  endfunction : gdr_bin2gray

  function automatic logic [7:0] gdr_gray2bin(input logic [7:0] g);
    logic [7:0] b;
    b[7] = g[7];
    for (int i = 6; i >= 0; i--)
      b[i] = b[i+1] ^ g[i];
    return b;
  endfunction : gdr_gray2bin
endpackage : gdr_pkg

// *** src/gdr_link_if.sv ***
`timescale 1ns/1ps
interface gdr_link_if;
  logic [7:0]  rx_gray;
  logic [15:0] rx_word;
  logic [43:0] snap;
  modport link (output rx_gray, output rx_word, input snap);
  modport core (input rx_gray, input rx_word, output snap);
endinterface : gdr_link_if

// *** src/gdr_spi_link.sv ***
`timescale 1ns/1ps
module gdr_spi_link (
  input  wire logic rst,
  input  wire logic spi_sclk,
  input  wire logic spi_cs_n,
  input  wire logic spi_sdi,
  output logic      spi_sdo,
  output logic      spi_sdo_oe,
  gdr_link_if.link  link
);
  import gdr_pkg::*;

  logic [15:0] rx_shift;
  logic [7:0]  rx_bin;
  logic [7:0]  rx_gray;
  logic [4:0]  tx_cnt;
  logic [10:0] tx_shift;
  wire         tx_clr = rst | spi_cs_n;
  wire  [3:0]  rx_addr = rx_shift[3:0];
  wire  [7:0]  next_rx_bin = rx_bin + 8'h01;
  wire  [10:0] word_sel = (rx_addr[3:2] == 2'b00) ? link.snap[rx_addr[1:0]*REG_W +: REG_W] : 11'h000;

  assign link.rx_word = rx_shift;
  assign link.rx_gray = rx_gray;

  // Free running count, so frame length is judged in the core without a reset crossing
  always_ff @(negedge spi_sclk or posedge rst)
  begin
    if (rst)
    begin
      rx_shift <= 16'h0000;
      rx_bin   <= 8'h00;
      rx_gray  <= 8'h00;
    end
    else if (!spi_cs_n)
    begin
      rx_shift <= {rx_shift[14:0], spi_sdi};
      rx_bin   <= next_rx_bin;
      rx_gray  <= gdr_bin2gray(next_rx_bin);
    end
  end

  // Snapshot is frozen by the core for the whole frame
  always_ff @(posedge spi_sclk or posedge tx_clr)
  begin
    if (tx_clr)
    begin
      tx_cnt     <= 5'h00;
      tx_shift   <= 11'h000;
      spi_sdo    <= 1'b0;
      spi_sdo_oe <= 1'b0;
    end
    else
    begin
      spi_sdo_oe <= 1'b1;
      tx_cnt     <= (tx_cnt == 5'h1f) ? tx_cnt : tx_cnt + 5'h01;
      if (tx_cnt == TX_DATA_START)
      begin
        spi_sdo  <= word_sel[10];
        tx_shift <= {word_sel[9:0], 1'b0};
      end
      else if (tx_cnt > TX_DATA_START)
      begin
        spi_sdo  <= tx_shift[10];
        tx_shift <= {tx_shift[9:0], 1'b0};
      end
      else
        spi_sdo <= 1'b0;
    end
  end
endmodule : gdr_spi_link

// *** src/gdr_regs.sv ***
`timescale 1ns/1ps
module gdr_regs (
  input  wire logic            clk,
  input  wire logic            rst,
  input  wire logic            spi_sclk,
  input  wire logic            spi_cs_n,
  input  wire logic            spi_sdi,
  output logic                 spi_sdo,
  output logic                 spi_sdo_oe,
  input  wire logic [5:0]      drain_oc_in,
  input  wire logic [5:0]      gate_err_in,
  input  wire logic [2:0]      sense_amp_oc_in,
  input  wire logic            overheat_shutdown_in,
  input  wire logic            overheat_warning_in,
  input  wire logic            supply_low_lockout_in,
  input  wire logic            pump_undervoltage_in,
  input  wire logic            sleep_in,
  input  wire logic            phase_c_high_input,
  input  wire logic            phase_c_low_input,
  output logic                 error_out_pin_n,
  output gdr_pkg::gdr_pwm_mode_t pwm_mode,
  output logic                 single_input_freewheel_sel,
  output logic                 eff_direction,
  output logic                 coast_all,
  output logic                 brake_low_all
);
  import gdr_pkg::*;

  gdr_link_if link ();

  logic [22:0] pin_meta;
  logic [22:0] pin_sync;
  logic [23:0] rx_meta;
  logic [23:0] rx_sync;
  logic        cs_q;
  logic        supply_low_lockout_q;
  logic [7:0]  start_cnt;
  logic [9:0]  st1;
  logic [10:0] st2;
  logic        fault;
  logic [10:0] ctrl;
  logic [2:0]  lock;
  logic        clr_cmd;
  logic [43:0] snap;

  wire [22:0] pin_raw = {spi_cs_n, sleep_in, supply_low_lockout_in, overheat_shutdown_in,
                         overheat_warning_in, pump_undervoltage_in, phase_c_high_input,
                         phase_c_low_input, sense_amp_oc_in, gate_err_in, drain_oc_in};

  wire [5:0] drain_ev  = pin_sync[5:0];
  wire [5:0] gate_raw  = pin_sync[11:6];
  wire [2:0] sense_ev  = pin_sync[14:12];
  wire       brake_pin = pin_sync[15];
  wire       dir_pin   = pin_sync[16];
  wire       pump_raw  = pin_sync[17];
  wire       warn_ev   = pin_sync[18];
  wire       overheat_shutdown_ev   = pin_sync[19];
  wire       supply_low_lockout_ev   = pin_sync[20];
  wire       sleep     = pin_sync[21];
  wire       cs_n      = pin_sync[22];

  // Frame bounds come from the synchronised select
  wire        frame_start = cs_q & ~cs_n;
  wire        frame_end   = ~cs_q & cs_n;
  wire        idle        = cs_q & cs_n;
  wire [7:0]  rx_cnt      = gdr_gray2bin(rx_sync[23:16]);
  wire [15:0] cmd         = rx_sync[15:0];
  wire [7:0]  frame_len   = rx_cnt - start_cnt;
  wire        frame_ok    = frame_end && (frame_len == FRAME_BITS);
  wire        is_read     = cmd[15];
  wire [3:0]  addr        = cmd[14:11];
  wire [10:0] data        = cmd[10:0];
  wire        wr          = frame_ok & ~is_read;
  wire        wr_ctrl     = wr && (addr == ADDR_CTRL);
  wire        wr_lock     = wr && (addr == ADDR_LOCK);
  wire        locked      = (lock == LOCK_ON);

  // Supply lockout is taken on its rising edge so its own flag can still latch
  wire        supply_low_lockout_rise   = supply_low_lockout_ev & ~supply_low_lockout_q;
  wire        reg_reset   = sleep | supply_low_lockout_rise;

  // Control word, with masks narrowing while locked
  wire [10:0] ctrl_mask   = locked ? CTRL_LOCK_MASK : CTRL_OPEN_MASK;
  wire [10:0] ctrl_wr     = (ctrl & ~ctrl_mask) | (data & ctrl_mask);
  wire [10:0] next_ctrl   = reg_reset ? CTRL_RST : (wr_ctrl ? ctrl_wr : ctrl);

  wire        lock_set    = wr_lock && !locked && (data[10:8] == LOCK_ON);
  wire        lock_clr    = wr_lock && locked && (data[10:8] == LOCK_OFF);
  wire [2:0]  next_lock   = reg_reset ? LOCK_RST : (lock_set ? LOCK_ON : (lock_clr ? LOCK_OFF : lock));

  wire        next_clr    = wr_ctrl & data[C_CLEAR];

  // Event qualifiers
  wire [5:0]  gate_ev     = gate_raw & {6{~ctrl[C_DIS_GATE]}};
  wire        pump_ev     = pump_raw & ~ctrl[C_DIS_PUMP];
  wire [9:0]  ev1         = {|drain_ev, |gate_ev, supply_low_lockout_ev, overheat_shutdown_ev, drain_ev};
  wire [10:0] ev2         = {sense_ev, warn_ev, pump_ev, gate_ev};
  wire        st_wipe     = clr_cmd | reg_reset;

  // Set wins over clear; sleep holds everything at default
  wire [9:0]  next_st1    = (st_wipe ? 10'h000 : st1) | (sleep ? 10'h000 : ev1);
  wire [10:0] next_st2    = (st_wipe ? 11'h000 : st2) | (sleep ? 11'h000 : ev2);
  wire        next_fault  = (|next_st1[9:6]) | (|next_st2[10:8]) | next_st2[6]
                          | (next_st2[7] & next_ctrl[C_WARN_REP]);

  wire        single      = (ctrl[6:5] == PWM_SINGLE);
  wire [43:0] next_snap   = {lock, 8'h00, ctrl, st2, fault, st1};

  assign link.snap = snap;

  gdr_spi_link u_link (
    .rst        (rst),
    .spi_sclk   (spi_sclk),
    .spi_cs_n   (spi_cs_n),
    .spi_sdi    (spi_sdi),
    .spi_sdo    (spi_sdo),
    .spi_sdo_oe (spi_sdo_oe),
    .link       (link.link)
  );

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pin_meta <= SYNC_RST;
      pin_sync <= SYNC_RST;
      rx_meta  <= 24'h000000;
      rx_sync  <= 24'h000000;
    end
    else
    begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
      rx_meta  <= {link.rx_gray, link.rx_word};
      rx_sync  <= rx_meta;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      cs_q      <= 1'b1;
      supply_low_lockout_q    <= 1'b0;
      start_cnt <= 8'h00;
    end
    else
    begin
      cs_q      <= cs_n;
      supply_low_lockout_q    <= supply_low_lockout_ev;
      start_cnt <= frame_start ? rx_cnt : start_cnt;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st1   <= 10'h000;
      st2   <= 11'h000;
      fault <= 1'b0;
      ctrl  <= CTRL_RST;
      lock  <= LOCK_RST;
    end
    else
    begin
      st1   <= next_st1;
      st2   <= next_st2;
      fault <= next_fault;
      ctrl  <= next_ctrl;
      lock  <= next_lock;
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      clr_cmd         <= 1'b0;
      error_out_pin_n <= 1'b1;
      snap            <= 44'h0;
    end
    else
    begin
      clr_cmd         <= next_clr;
      error_out_pin_n <= ~next_fault;
      snap            <= idle ? next_snap : snap;
    end
  end

  // Mode outputs follow the stored control word; freewheel, direction and brake only in single mode, where direction and brake also follow the phase C pins
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pwm_mode                   <= PWM_SIX;
      single_input_freewheel_sel <= 1'b0;
      eff_direction              <= 1'b0;
      coast_all                  <= 1'b0;
      brake_low_all              <= 1'b0;
    end
    else
    begin
      pwm_mode                   <= gdr_pwm_mode_t'(ctrl[6:5]);
      single_input_freewheel_sel <= single & ctrl[C_FREEWHEEL];
      eff_direction              <= single & (ctrl[C_DIR] | dir_pin);
      coast_all                  <= ctrl[C_COAST];
      brake_low_all              <= single & (ctrl[C_BRAKE] | brake_pin);
    end
  end

  property p_pin_mirror;
    @(posedge clk) disable iff (rst)
    error_out_pin_n == ~fault;
  endproperty
  a_pin_mirror: assert property (p_pin_mirror) else $error("error pin differs from summary bit");

  property p_summary;
    @(posedge clk) disable iff (rst)
    fault == ((|st1[9:6]) | (|st2[10:8]) | st2[6] | (st2[7] & ctrl[C_WARN_REP]));
  endproperty
  a_summary: assert property (p_summary) else $error("summary bit wrong");

  property p_stat_ro;
    @(posedge clk) disable iff (rst)
    wr && (addr == ADDR_STAT1) && (ev1 == 10'h000) && !st_wipe |=> st1 == $past(st1);
  endproperty
  a_stat_ro: assert property (p_stat_ro) else $error("status write altered flags");

  property p_lockout_flag;
    @(posedge clk) disable iff (rst)
    supply_low_lockout_ev && !sleep |=> st1[7] ##1 ctrl == CTRL_RST;
  endproperty
  a_lockout_flag: assert property (p_lockout_flag) else $error("lockout flag or reset missing");

  property p_drain_bit;
    @(posedge clk) disable iff (rst)
    drain_ev[5] && !sleep |=> st1[5] && st1[9];
  endproperty
  a_drain_bit: assert property (p_drain_bit) else $error("drain flag not set");

  property p_pump_off;
    @(posedge clk) disable iff (rst)
    ctrl[C_DIS_PUMP] && !st2[6] |=> !st2[6];
  endproperty
  a_pump_off: assert property (p_pump_off) else $error("pump error not suppressed");

  property p_gate_off;
    @(posedge clk) disable iff (rst)
    ctrl[C_DIS_GATE] && (st2[5:0] == 6'h00) && !st1[8] |=> (st2[5:0] == 6'h00) && !st1[8];
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("gate error not suppressed");

  property p_clear;
    @(posedge clk) disable iff (rst)
    next_clr && !sleep ##1 (ev1 == 10'h000) |=> (st1 == 10'h000) && !clr_cmd && !ctrl[C_CLEAR];
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not empty flags");

  property p_locked_hold;
    @(posedge clk) disable iff (rst)
    locked && wr_ctrl && !reg_reset |=> ctrl[10:3] == $past(ctrl[10:3]);
  endproperty
  a_locked_hold: assert property (p_locked_hold) else $error("locked write changed control");

  property p_defaults;
    @(posedge clk) disable iff (rst)
    sleep |=> (ctrl == CTRL_RST) && (lock == LOCK_RST) && (st2 == 11'h000);
  endproperty
  a_defaults: assert property (p_defaults) else $error("sleep did not restore defaults");

  property p_snap_frozen;
    @(posedge clk) disable iff (rst)
    !cs_n && !cs_q |=> $stable(snap);
  endproperty
  a_snap_frozen: assert property (p_snap_frozen) else $error("snapshot moved during frame");

  property p_sense_flag;
    @(posedge clk) disable iff (rst)
    sense_ev[2] && !sleep |=> st2[10] && fault;
  endproperty
  a_sense_flag: assert property (p_sense_flag) else $error("sense flag not set");

  property p_gate_bit;
    @(posedge clk) disable iff (rst)
    gate_ev[0] && !sleep |=> st2[0] && st1[8];
  endproperty
  a_gate_bit: assert property (p_gate_bit) else $error("gate flag not set");

  property p_mode_out;
    @(posedge clk) disable iff (rst)
    pwm_mode == $past(ctrl[6:5]);
  endproperty
  a_mode_out: assert property (p_mode_out) else $error("mode output lags wrongly");

  property p_coast_out;
    @(posedge clk) disable iff (rst)
    coast_all == $past(ctrl[C_COAST]);
  endproperty
  a_coast_out: assert property (p_coast_out) else $error("coast output wrong");

  property p_brake_out;
    @(posedge clk) disable iff (rst)
    brake_low_all == $past((ctrl[6:5] == PWM_SINGLE) && (ctrl[C_BRAKE] || brake_pin));
  endproperty
  a_brake_out: assert property (p_brake_out) else $error("brake output wrong");
endmodule : gdr_regs

// *** verif/gdr_spi_master.sv ***
`timescale 1ns/1ps
module gdr_spi_master (
  input  wire logic        start,
  input  wire logic [15:0] tx_word,
  input  wire logic [7:0]  nbits,
  input  wire logic        spi_sdo,
  output logic             busy,
  output logic [15:0]      rx_word,
  output logic             spi_sclk,
  output logic             spi_cs_n,
  output logic             spi_sdi
);
  initial
  begin
    busy     = 1'b0;
    rx_word  = 16'h0000;
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_sdi  = 1'b0;
  end

  // Clock runs only inside a frame, low at both select edges
  always @(posedge start)
  begin
    busy = 1'b1;
    #7;
    spi_cs_n = 1'b0;
    #250;
    for (int i = 0; i < nbits; i++)
    begin
      spi_sclk = 1'b1;
      spi_sdi  = tx_word[15 - i];
      #62.5;
      spi_sclk = 1'b0;
      rx_word  = {rx_word[14:0], spi_sdo};
      #62.5;
    end
    spi_cs_n = 1'b1;
    // Released line flips so a stale level is never mistaken for data
    spi_sdi = ~spi_sdi;
    #450;
    busy = 1'b0;
  end
endmodule : gdr_spi_master

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  import gdr_pkg::*;
  logic          clk       = 1'b0;
  logic          rst       = 1'b1;
  logic          start     = 1'b0;
  logic [15:0]   tx_word   = 16'h0000;
  logic [7:0]    nbits     = 8'h10;
  logic [5:0]    drain_oc  = 6'h00;
  logic [5:0]    gate_err  = 6'h00;
  logic [2:0]    sense_oc  = 3'h0;
  logic [3:0]    misc      = 4'h0;
  logic          sleep     = 1'b0;
  logic          dir_pin   = 1'b0;
  logic          brake_pin = 1'b0;
  logic          busy, sclk, cs_n, sdi, sdo, sdo_oe, err_n, fw, dir, coast, brake;
  logic [15:0]   rx_word;
  gdr_pwm_mode_t mode;
  int            num_errors = 0;
  int            checks     = 0;
  wire  [5:0]    outs       = {mode, fw, dir, coast, brake};
  // Undriven output shows the opposite level, so a late enable corrupts the answer
  wire           sdo_line   = sdo_oe ? sdo : ~sdo;

  initial
  begin
    forever #20 clk = ~clk;
  end

  gdr_spi_master master (.start(start), .tx_word(tx_word), .nbits(nbits), .spi_sdo(sdo_line), .busy(busy),
    .rx_word(rx_word), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_sdi(sdi));

  gdr_regs uut (.clk(clk), .rst(rst), .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_sdi(sdi), .spi_sdo(sdo),
    .spi_sdo_oe(sdo_oe), .drain_oc_in(drain_oc), .gate_err_in(gate_err), .sense_amp_oc_in(sense_oc),
    .overheat_shutdown_in(misc[3]), .overheat_warning_in(misc[2]), .supply_low_lockout_in(misc[1]),
    .pump_undervoltage_in(misc[0]), .sleep_in(sleep), .phase_c_high_input(dir_pin),
    .phase_c_low_input(brake_pin), .error_out_pin_n(err_n), .pwm_mode(mode),
    .single_input_freewheel_sel(fw), .eff_direction(dir), .coast_all(coast), .brake_low_all(brake));

  task automatic wrap_up;
    if (num_errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic hold(input int n);
    repeat (n) @(posedge clk);
  endtask : hold

  // One frame; answer top five bits must be zero
  task automatic xf(input logic rw, input logic [3:0] a, input logic [10:0] d, input logic [10:0] e, input bit ck);
    @(posedge clk);
    tx_word <= {rw, a, d};
    start   <= 1'b1;
    for (int i = 0; i < 20 && busy !== 1'b1; i++)
      @(posedge clk);
    start <= 1'b0;
    check({15'h0, busy}, 16'h0001);
    hold(10);
    check({15'h0, sdo_oe}, 16'h0001);
    for (int i = 0; i < 400 && busy !== 1'b0; i++)
      @(posedge clk);
    check({15'h0, busy}, 16'h0000);
    hold(2);
    check({15'h0, sdo_oe}, 16'h0000);
    if (ck)
      check(rx_word, {5'h00, e});
  endtask : xf

  task automatic rd(input logic [3:0] a, input logic [10:0] e);
    xf(1'b1, a, 11'h000, e, 1'b1);
  endtask : rd

  task automatic wr(input logic [3:0] a, input logic [10:0] d);
    xf(1'b0, a, d, 11'h000, 1'b0);
  endtask : wr

  // Pulse a fault set, read both words, then clear
  task automatic flt(input logic [3:0] mi, input logic [5:0] ge, input logic [2:0] so, input logic [10:0] c,
                     input logic [10:0] e1, input logic [10:0] e2);
    wr(ADDR_CTRL, c);
    misc     <= mi;
    gate_err <= ge;
    sense_oc <= so;
    hold(4);
    misc     <= 4'h0;
    gate_err <= 6'h00;
    sense_oc <= 3'h0;
    hold(2);
    rd(ADDR_STAT1, e1);
    rd(ADDR_STAT2, e2);
    check({15'h0, err_n}, {15'h0, ~e1[10]});
    wr(ADDR_CTRL, 11'h001);
  endtask : flt

  initial
  begin
    // Generous bound: about 330 frames of three microseconds
    #1000000;
    num_errors++;
    wrap_up();
  end

  initial
  begin
    hold(2);
    rst <= 1'b0;
    hold(4);
    rd(ADDR_STAT1, 11'h000);
    rd(ADDR_STAT2, 11'h000);
    rd(ADDR_CTRL, CTRL_RST);
    rd(ADDR_LOCK, 11'h300);
    check({15'h0, err_n}, 16'h0001);
    xf(1'b0, ADDR_CTRL, 11'h7ff, 11'h000, 1'b1);
    xf(1'b1, ADDR_CTRL, 11'h000, 11'h3fe, 1'b1);
    check({10'h0, outs}, 16'h0032);
    for (int m = 0; m < 4; m++)
    begin
      wr(ADDR_CTRL, {4'h0, m[1:0], 5'h1a});
      check({10'h0, outs}, {10'h0, m[1:0], m == 2, m == 2, 1'b0, m == 2});
    end
    wr(ADDR_CTRL, 11'h040);
    dir_pin   <= 1'b1;
    brake_pin <= 1'b1;
    hold(5);
    check({10'h0, outs}, 16'h0025);
    dir_pin   <= 1'b0;
    brake_pin <= 1'b0;
    wr(ADDR_CTRL, 11'h000);
    for (int i = 0; i < 6; i++)
    begin
      drain_oc <= 6'h01 << i;
      gate_err <= 6'h01 << i;
      hold(4);
      drain_oc <= 6'h00;
      gate_err <= 6'h00;
      hold(2);
      check({15'h0, err_n}, 16'h0000);
      rd(ADDR_STAT1, 11'h700 | (11'h001 << i));
      rd(ADDR_STAT1, 11'h700 | (11'h001 << i));
      rd(ADDR_STAT2, 11'h001 << i);
      wr(ADDR_CTRL, 11'h001);
      rd(ADDR_STAT1, 11'h000);
    end
    flt(4'h8, 6'h00, 3'h0, 11'h000, 11'h440, 11'h000);
    flt(4'h4, 6'h00, 3'h0, 11'h000, 11'h000, 11'h080);
    flt(4'h4, 6'h00, 3'h0, 11'h080, 11'h400, 11'h080);
    flt(4'h1, 6'h00, 3'h0, 11'h000, 11'h400, 11'h040);
    flt(4'h1, 6'h00, 3'h0, 11'h200, 11'h000, 11'h000);
    flt(4'h0, 6'h3f, 3'h0, 11'h100, 11'h000, 11'h000);
    flt(4'h0, 6'h00, 3'h5, 11'h000, 11'h400, 11'h500);
    wr(ADDR_CTRL, 11'h080);
    misc <= 4'h2;
    hold(4);
    misc <= 4'h0;
    hold(2);
    rd(ADDR_CTRL, 11'h000);
    rd(ADDR_STAT1, 11'h480);
    wr(ADDR_CTRL, 11'h001);
    wr(ADDR_CTRL, 11'h080);
    sleep <= 1'b1;
    hold(4);
    sleep <= 1'b0;
    hold(4);
    rd(ADDR_CTRL, 11'h000);
    xf(1'b0, ADDR_LOCK, 11'h600, 11'h300, 1'b1);
    wr(ADDR_CTRL, 11'h3fe);
    rd(ADDR_CTRL, 11'h006);
    wr(ADDR_LOCK, 11'h100);
    rd(ADDR_LOCK, 11'h600);
    wr(ADDR_LOCK, 11'h300);
    wr(ADDR_CTRL, 11'h080);
    rd(ADDR_CTRL, 11'h080);
    wr(ADDR_STAT1, 11'h7ff);
    wr(ADDR_STAT2, 11'h7ff);
    rd(ADDR_STAT1, 11'h000);
    rd(ADDR_STAT2, 11'h000);
    rd(4'h9, 11'h000);
    nbits <= 8'h0f;
    wr(ADDR_CTRL, 11'h060);
    nbits <= 8'h10;
    rd(ADDR_CTRL, 11'h080);
    wrap_up();
  end
endmodule : tb_top
